// *** eeprom_guard_pkg.sv ***
// Purpose: Shared constants and types for the serial memory write guard.
// Assumes: A 25 MHz system clock samples every link pin.
// Notes: Word-organised array with sixteen-bit words.
package eeprom_guard_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int CNT_W = 8;

    localparam int CLK_PERIOD_NS = 40;
    localparam int GLITCH_NS = 20;
    localparam int GLITCH_CYC_RAW =
        (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GLITCH_CYC = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
    localparam int PROG_TIME_US = 8000;
    localparam int PROG_CYC = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

    // Two opcode bits follow the start bit.
    localparam logic [1:0] OPC_EXT = 2'h0;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    // Top two address bits select the extended instruction.
    localparam logic [1:0] EXT_LOCK = 2'h0;
    localparam logic [1:0] EXT_ARRAY_PROGRAM = 2'h1;
    localparam logic [1:0] EXT_ARRAY_CLEAR = 2'h2;
    localparam logic [1:0] EXT_UNLOCK = 2'h3;

    // Clock counts include the start bit.
    localparam int SHORT_COUNT = 1 + 2 + ADDR_W;
    localparam int LONG_COUNT = SHORT_COUNT + DATA_W;
    localparam int SHIFT_W = 2 + ADDR_W + DATA_W;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_WRITE,
        OP_ERASE,
        OP_ARRAY_PROGRAM,
        OP_ARRAY_CLEAR
    } prog_op_t;

    typedef struct packed {
        prog_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } prog_cmd_t;

endpackage

// *** pin_filter.sv ***
// Purpose: Three-stage synchroniser with a pulse-width filter for one pin.
// Assumes: The pin is asynchronous to sys_clk.
// Notes: A level is taken once two later stages agree for STABLE_CYC cycles.
`timescale 1ns/1ps
module pin_filter #(
    parameter int STABLE_CYC = 1,
    parameter logic INIT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic pin,
    output logic level
);
    localparam int CW = $clog2(STABLE_CYC + 1) + 1;
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic [CW-1:0] hold_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A short pulse resets the count and never reaches the output.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= '0;
            level <= INIT;
        end else if (s2_q != s3_q || s3_q == level) begin
            hold_q <= '0;
        end else if (hold_q >= CW'(STABLE_CYC - 1)) begin
            hold_q <= '0;
            level <= s3_q;
        end else begin
            hold_q <= hold_q + CW'(1);
        end
    end
endmodule // pin_filter

// *** eeprom_write_guard.sv ***
// Purpose: Instruction capture and write protection of a serial memory.
// Assumes: reset_n is the power-on condition; supply_low is the detector.
// Notes: Starts programming by a pulse; the array itself lives outside.
// How it works
// - Write-class instructions are dropped while the supply is low.
// - Low supply or power-up clears the program-enable state.
// - A word being programmed when the supply fails is flagged bad.
// - A write-class instruction with a wrong clock count is dropped.
// - A short instruction with surplus clocks never changes memory.
// - Nothing is started or latched while select is low.
// - Pulses of 20 ns or less on select, clock and data are ignored.
// - Write-class instructions run only in program-enable mode.
// - Programming starts at select fall; clock and data are then idle.
// - In verify, data out is low while busy and high when done.
// - Unlock and lock take effect at the select fall after the address.
`timescale 1ns/1ps
module eeprom_write_guard #(
    parameter int PROG_CYCLES = eeprom_guard_pkg::PROG_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic chip_select,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic supply_low,
    output logic serial_out,
    output logic serial_out_oe,
    output logic program_enabled,
    output logic prog_busy,
    output logic prog_start,
    output eeprom_guard_pkg::prog_cmd_t prog_cmd,
    output logic word_undefined
);
    localparam int A = eeprom_guard_pkg::ADDR_W;
    localparam int D = eeprom_guard_pkg::DATA_W;
    localparam int CW = eeprom_guard_pkg::CNT_W;
    localparam int SW = eeprom_guard_pkg::SHIFT_W;
    localparam int TW = $clog2(PROG_CYCLES + 1);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_PROG
    } state_t;

    logic cs_f;
    logic sk_f;
    logic di_f;
    logic low_f;
    logic cs_q;
    logic sk_q;
    state_t state_q;
    logic [CW-1:0] count_q;
    logic [SW-1:0] shift_q;
    logic [TW-1:0] timer_q;
    logic verify_q;
    logic sk_rise;
    logic cs_fall;
    logic cs_rise;
    logic start_bit;
    logic [1:0] opc;
    logic [1:0] ext;
    eeprom_guard_pkg::prog_cmd_t cmd;
    logic cmd_write_class;
    logic count_ok;

    // Every pin, the detector flag included, goes through the filter.
    pin_filter #(.STABLE_CYC(eeprom_guard_pkg::GLITCH_CYC), .INIT(1'b0))
        u_cs (.sys_clk(sys_clk), .reset_n(reset_n), .pin(chip_select),
              .level(cs_f));
    pin_filter #(.STABLE_CYC(eeprom_guard_pkg::GLITCH_CYC), .INIT(1'b0))
        u_sk (.sys_clk(sys_clk), .reset_n(reset_n), .pin(serial_clock),
              .level(sk_f));
    pin_filter #(.STABLE_CYC(eeprom_guard_pkg::GLITCH_CYC), .INIT(1'b0))
        u_di (.sys_clk(sys_clk), .reset_n(reset_n), .pin(serial_in),
              .level(di_f));
    pin_filter #(.STABLE_CYC(1), .INIT(1'b1))
        u_low (.sys_clk(sys_clk), .reset_n(reset_n), .pin(supply_low),
               .level(low_f));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_q <= 1'b0;
            sk_q <= 1'b0;
        end else begin
            cs_q <= cs_f;
            sk_q <= sk_f;
        end
    end

    assign sk_rise = sk_f && !sk_q && cs_f;
    assign cs_fall = !cs_f && cs_q;
    assign cs_rise = cs_f && !cs_q;
    assign start_bit = (state_q == ST_IDLE) && sk_rise && di_f;

    // Decode both instruction lengths from the shifted bits.
    always_comb begin
        cmd = '0;
        cmd_write_class = 1'b0;
        if (count_q == CW'(eeprom_guard_pkg::LONG_COUNT)) begin
            opc = shift_q[SW-1 -: 2];
            ext = shift_q[D+A-1 -: 2];
            cmd.addr = shift_q[D +: A];
            cmd.data = shift_q[D-1:0];
            if (opc == eeprom_guard_pkg::OPC_WRITE) begin
                cmd.op = eeprom_guard_pkg::OP_WRITE;
            end else if (opc == eeprom_guard_pkg::OPC_EXT &&
                         ext == eeprom_guard_pkg::EXT_ARRAY_PROGRAM) begin
                cmd.op = eeprom_guard_pkg::OP_ARRAY_PROGRAM;
            end
        end else begin
            opc = shift_q[A+1 -: 2];
            ext = shift_q[A-1 -: 2];
            cmd.addr = shift_q[A-1:0];
            cmd.data = '1;
            if (opc == eeprom_guard_pkg::OPC_ERASE) begin
                cmd.op = eeprom_guard_pkg::OP_ERASE;
            end else if (opc == eeprom_guard_pkg::OPC_EXT &&
                         ext == eeprom_guard_pkg::EXT_ARRAY_CLEAR) begin
                cmd.op = eeprom_guard_pkg::OP_ARRAY_CLEAR;
            end
        end
        cmd_write_class = (cmd.op != eeprom_guard_pkg::OP_NONE);
    end

    // Only exact short or long counts decode; any other count is no op.
    assign count_ok = (count_q == CW'(eeprom_guard_pkg::SHORT_COUNT)) ||
                      (count_q == CW'(eeprom_guard_pkg::LONG_COUNT));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_bit) begin
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (cs_fall) begin
                        if (count_ok && cmd_write_class && program_enabled
                                && !low_f) begin
                            state_q <= ST_PROG;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_PROG: begin
                    if (low_f || timer_q == '0) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Count and shift only while an instruction is open, never in ST_PROG.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
            shift_q <= '0;
        end else if (start_bit) begin
            count_q <= CW'(1);
            shift_q <= '0;
        end else if (state_q == ST_SHIFT && sk_rise) begin
            if (count_q != '1) begin
                count_q <= count_q + CW'(1);
            end
            shift_q <= {shift_q[SW-2:0], di_f};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            program_enabled <= 1'b0;
        end else if (low_f) begin
            program_enabled <= 1'b0;
        end else if (state_q == ST_SHIFT && cs_fall &&
                     count_q == CW'(eeprom_guard_pkg::SHORT_COUNT) &&
                     opc == eeprom_guard_pkg::OPC_EXT) begin
            if (ext == eeprom_guard_pkg::EXT_UNLOCK) begin
                program_enabled <= 1'b1;
            end else if (ext == eeprom_guard_pkg::EXT_LOCK) begin
                program_enabled <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_q <= '0;
            prog_start <= 1'b0;
            prog_cmd <= '0;
        end else begin
            prog_start <= 1'b0;
            if (state_q == ST_SHIFT && cs_fall && count_ok &&
                    cmd_write_class && program_enabled && !low_f) begin
                timer_q <= TW'(PROG_CYCLES - 1);
                prog_start <= 1'b1;
                prog_cmd <= cmd;
            end else if (state_q == ST_PROG && timer_q != '0) begin
                timer_q <= timer_q - TW'(1);
            end
        end
    end

    // The word under way at a supply failure is reported, not assumed.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_undefined <= 1'b0;
        end else begin
            word_undefined <= (state_q == ST_PROG) && low_f;
        end
    end

    assign prog_busy = (state_q == ST_PROG);

    // Verify lasts from a select rise while busy until select falls or a start bit.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            verify_q <= 1'b0;
        end else if (!cs_f || start_bit) begin
            verify_q <= 1'b0;
        end else if (cs_rise && state_q == ST_PROG) begin
            verify_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out <= (state_q != ST_PROG);
            serial_out_oe <= verify_q && cs_f && !start_bit;
        end
    end
endmodule // eeprom_write_guard

// *** guard_checks_asserts.sv ***
// Purpose: Port-level checks of the serial memory write guard.
// Assumes: Sees only the top module's ports.
// Notes: Bound to every instance of the guard at the foot.
`timescale 1ns/1ps
module guard_checks #(
    parameter int PROG_CYCLES = eeprom_guard_pkg::PROG_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic chip_select,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic supply_low,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic program_enabled,
    input wire logic prog_busy,
    input wire logic prog_start,
    input wire eeprom_guard_pkg::prog_cmd_t prog_cmd,
    input wire logic word_undefined
);
    int busy_n;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_n <= 0;
        end else begin
            busy_n <= prog_busy ? busy_n + 1 : 0;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_start_enabled:
    assert property (prog_start |-> program_enabled)
        else $error("start while locked");
    a_low_no_start:
    assert property (supply_low [*8] |=> !prog_start)
        else $error("start under low supply");
    a_select_no_start:
    assert property (chip_select [*8] |=> !prog_start)
        else $error("start while select high");
    a_busy_after_start:
    assert property (prog_start |=> prog_busy)
        else $error("busy missing after start");
    a_busy_bound:
    assert property (busy_n <= PROG_CYCLES)
        else $error("busy too long");
    a_low_locks:
    assert property (supply_low [*8] |=> !program_enabled)
        else $error("enabled under low supply");
    a_undef_locks:
    assert property (word_undefined |-> ##[0:2] !program_enabled)
        else $error("abort left device enabled");
    a_undef_busy:
    assert property (word_undefined |-> $past(prog_busy))
        else $error("undefined word outside programming");
    a_out_busy_low:
    assert property (serial_out_oe && prog_busy |-> !serial_out)
        else $error("ready shown while busy");
    a_cmd_stable:
    assert property (!prog_start |-> $stable(prog_cmd))
        else $error("command changed without a start");
    a_low_select_idle:
    assert property (!chip_select [*8] |=> !prog_start)
        else $error("start while select low");
    a_start_at_fall:
    assert property (prog_start |-> !chip_select && !$past(chip_select, 4))
        else $error("start without a select fall");
    c_start: cover property (prog_start);
    c_busy_shown: cover property (serial_out_oe && !serial_out);
    c_abort: cover property (word_undefined);
    c_ready: cover property (serial_out_oe && serial_out);
endmodule // guard_checks

bind eeprom_write_guard guard_checks #(.PROG_CYCLES(PROG_CYCLES)) chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in),
    .supply_low(supply_low), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .program_enabled(program_enabled),
    .prog_busy(prog_busy), .prog_start(prog_start),
    .prog_cmd(prog_cmd), .word_undefined(word_undefined));

// *** host_link_model.sv ***
// Purpose: Host side of the three-wire link.
// Assumes: Link clock half period is four sys_clk cycles.
// Notes: Link clock stands low outside frames.
`timescale 1ns/1ps
module host_link_model (
    input wire logic sys_clk,
    output logic chip_select,
    output logic serial_clock,
    output logic serial_in
);
    initial begin
        chip_select = 1'b0;
        serial_clock = 1'b0;
        serial_in = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Sends the low n bits of v, most significant first.
    task automatic frame(input logic [31:0] v, input int n);
        chip_select <= 1'b1;
        tick(4);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= v[i];
            tick(4);
            serial_clock <= 1'b1;
            tick(4);
            serial_clock <= 1'b0;
        end
        tick(4);
        chip_select <= 1'b0;
        serial_in <= ~serial_in;
        tick(8);
    endtask
    // Data stays low while select is held for a status check.
    // The level is held long enough to pass the pin filter.
    task automatic hold_select(input logic lvl);
        chip_select <= lvl;
        serial_in <= 1'b0;
        tick(8);
    endtask
    // A 20 ns spike on every pin, straddling one sys_clk edge.
    task automatic spike;
        @(negedge sys_clk);
        #10;
        serial_clock <= ~serial_clock;
        chip_select <= ~chip_select;
        serial_in <= ~serial_in;
        #20;
        serial_clock <= ~serial_clock;
        chip_select <= ~chip_select;
        serial_in <= ~serial_in;
    endtask
endmodule // host_link_model

// *** eeprom_write_guard_tb.sv ***
// Purpose: Self-checking bench of the write guard.
// Assumes: Short programming time parameter.
// Notes: Frames come from the host model.
`timescale 1ns/1ps
module eeprom_write_guard_tb;
    localparam int PC = 50;
    logic sys_clk, reset_n, supply_low, chip_select, serial_clock, serial_in;
    logic serial_out, serial_out_oe, program_enabled, prog_busy;
    logic prog_start, word_undefined;
    eeprom_guard_pkg::prog_cmd_t prog_cmd, last_cmd;
    int bad_count, n_checks, starts, undefs;
    host_link_model host (.sys_clk(sys_clk), .chip_select(chip_select),
        .serial_clock(serial_clock), .serial_in(serial_in));
    eeprom_write_guard #(.PROG_CYCLES(PC)) dut (.sys_clk(sys_clk),
        .reset_n(reset_n), .chip_select(chip_select),
        .serial_clock(serial_clock), .serial_in(serial_in),
        .supply_low(supply_low), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .program_enabled(program_enabled),
        .prog_busy(prog_busy), .prog_start(prog_start),
        .prog_cmd(prog_cmd), .word_undefined(word_undefined));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        if (prog_start === 1'b1) begin
            starts++;
            last_cmd = prog_cmd;
        end
        if (word_undefined === 1'b1) undefs++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] cmd(input logic [1:0] op,
        input logic [5:0] a, input logic [15:0] d);
        return {7'h00, 1'b1, op, a, d};
    endfunction
    task automatic send(input logic [31:0] v, input int n, input int exp);
        int s0;
        s0 = starts;
        host.frame(v, n);
        host.tick(12);
        check(starts - s0, exp);
    endtask
    task automatic wait_idle;
        int k;
        k = 0;
        while (prog_busy !== 1'b0 && k < 200) begin
            @(posedge sys_clk);
            k++;
        end
        check(prog_busy, 1'b0);
    endtask
    task automatic t_locked;
        check(program_enabled, 1'b0);
        send(cmd(2'h1, 6'h05, 16'hA5C3), 25, 0);
        send(cmd(2'h0, 6'h30, 16'h0000) >> 16, 9, 0);
        check(program_enabled, 1'b1);
    endtask
    task automatic t_counts;
        send(cmd(2'h0, 6'h00, 16'h0000) >> 15, 10, 0);
        check(program_enabled, 1'b1);
        send(cmd(2'h1, 6'h05, 16'hA5C3) >> 1, 24, 0);
        send(cmd(2'h1, 6'h05, 16'hA5C3) << 1, 26, 0);
        send(cmd(2'h1, 6'h05, 16'hA5C3) >> 16, 9, 0);
        send(cmd(2'h3, 6'h11, 16'h0000), 25, 0);
        send(cmd(2'h3, 6'h11, 16'h0000) >> 15, 10, 0);
        send(cmd(2'h3, 6'h11, 16'h0000) >> 17, 8, 0);
        send(cmd(2'h2, 6'h11, 16'h0000) >> 16, 9, 0);
    endtask
    task automatic t_write_verify;
        send(cmd(2'h1, 6'h2A, 16'h5A3C), 25, 1);
        check(last_cmd, {eeprom_guard_pkg::OP_WRITE, 6'h2A,
            16'h5A3C});
        host.hold_select(1'b1);
        host.tick(10);
        check({serial_out_oe, serial_out}, 2'h2);
        wait_idle();
        host.tick(2);
        check({serial_out_oe, serial_out}, 2'h3);
        host.hold_select(1'b0);
    endtask
    task automatic t_other_ops;
        send(cmd(2'h3, 6'h11, 16'h0000) >> 16, 9, 1);
        check(last_cmd, {eeprom_guard_pkg::OP_ERASE, 6'h11,
            16'hFFFF});
        wait_idle();
        send(cmd(2'h0, 6'h10, 16'h1234), 25, 1);
        check(last_cmd.op, eeprom_guard_pkg::OP_ARRAY_PROGRAM);
        wait_idle();
        send(cmd(2'h0, 6'h20, 16'h0000) >> 16, 9, 1);
        check(last_cmd.op, eeprom_guard_pkg::OP_ARRAY_CLEAR);
        wait_idle();
    endtask
    // Spikes land between two link clock pulses of a write frame.
    task automatic t_spike;
        int s0;
        s0 = starts;
        fork
            host.frame(cmd(2'h1, 6'h3C, 16'hC35A), 25);
            begin
                host.tick(45);
                host.spike();
            end
        join
        host.tick(12);
        check(starts - s0, 1);
        check(last_cmd, {eeprom_guard_pkg::OP_WRITE, 6'h3C,
            16'hC35A});
        wait_idle();
    endtask
    task automatic t_brownout;
        send(cmd(2'h1, 6'h07, 16'h00FF), 25, 1);
        supply_low <= 1'b1;
        host.tick(12);
        check(undefs, 1);
        check(last_cmd, {eeprom_guard_pkg::OP_WRITE, 6'h07,
            16'h00FF});
        check({prog_busy, program_enabled}, 2'h0);
        send(cmd(2'h0, 6'h30, 16'h0000) >> 16, 9, 0);
        check(program_enabled, 1'b0);
        send(cmd(2'h1, 6'h07, 16'h00FF), 25, 0);
        supply_low <= 1'b0;
        host.tick(10);
        send(cmd(2'h1, 6'h07, 16'h00FF), 25, 0);
        send(cmd(2'h0, 6'h30, 16'h0000) >> 16, 9, 0);
        send(cmd(2'h1, 6'h07, 16'h00FF), 25, 1);
        wait_idle();
    endtask
    // A second power application in mid-run must lock the device again.
    task automatic t_power;
        send(cmd(2'h0, 6'h30, 16'h0000) >> 16, 9, 0);
        check(program_enabled, 1'b1);
        reset_n <= 1'b0;
        host.tick(4);
        check({serial_out_oe, program_enabled}, 2'h0);
        reset_n <= 1'b1;
        host.tick(10);
        check(program_enabled, 1'b0);
        send(cmd(2'h1, 6'h09, 16'h1357), 25, 0);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #2000000;
        bad_count++;
        give_verdict();
    end
    initial begin
        reset_n = 1'b0;
        supply_low = 1'b0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        host.tick(10);
        t_locked();
        t_counts();
        t_write_verify();
        t_other_ops();
        t_spike();
        t_brownout();
        t_power();
        give_verdict();
    end
endmodule // eeprom_write_guard_tb
